// ===== rtl/fpt_consts.svh
// Constants for the flash patch unit: counts, address map, remap layout.
// Assumes a 32-bit byte address space with flash starting at address zero.
`ifndef FPT_CONSTS_SVH
`define FPT_CONSTS_SVH

`define FPT_NUM_INST      6
`define FPT_NUM_LIT       2
`define FPT_NUM_CMP       8
`define FPT_IDX_W         3
`define FPT_WORD_AW       30
`define FPT_FLASH_BASE    32'h0000_0000
`define FPT_FLASH_LIMIT   32'h2000_0000
`define FPT_SLOT_SHIFT    2
`define FPT_REMAP_LSB     5
`define FPT_BREAK_INSTR   16'h0000

`endif

// ===== rtl/fpt_pkg.sv
// Types shared by the flash patch unit modules.
// Assumes access size is coded as log2 of the byte count.
package fpt_pkg;

    typedef enum logic [1:0] {
        FPT_SZ_BYTE = 2'h0,
        FPT_SZ_HALF = 2'h1,
        FPT_SZ_WORD = 2'h2
    } fpt_size_t;

    typedef logic [31:0] fpt_addr_t;

endpackage : fpt_pkg

// ===== rtl/fpt_cmp_if.sv
// Carrier between the flash patch unit and its comparator bank.
// Assumes both ends run on the same clock; the bank is purely combinational.
`timescale 1ns/1ns
interface fpt_cmp_if #(
    parameter int NUM_CMP = 8,
    parameter int WORD_AW = 30
);
    logic                              globalEn;
    logic [NUM_CMP-1:0]                cmpEn;
    logic [NUM_CMP-1:0][WORD_AW-1:0]   cmpWordAddr;
    logic                              reqValid;
    logic                              reqIsFetch;
    logic                              reqAligned;
    logic                              reqInFlash;
    logic [WORD_AW-1:0]                reqWordAddr;
    logic [NUM_CMP-1:0]                hit;

    modport ctrl (
        output globalEn, cmpEn, cmpWordAddr, reqValid, reqIsFetch,
        output reqAligned, reqInFlash, reqWordAddr,
        input  hit
    );
    modport bank (
        input  globalEn, cmpEn, cmpWordAddr, reqValid, reqIsFetch,
        input  reqAligned, reqInFlash, reqWordAddr,
        output hit
    );
endinterface : fpt_cmp_if

// ===== rtl/fpt_match_bank.sv
// Comparator bank: one match term per comparator slot.
// Assumes slots below NUM_INST are instruction slots, the rest literal.
`timescale 1ns/1ns
module fpt_match_bank #(
    parameter int NUM_CMP  = 8,
    parameter int NUM_INST = 6
) (
    fpt_cmp_if.bank bus
);

    genvar i;
    generate
        for (i = 0; i < NUM_CMP; i = i + 1) begin : g_slot
            wire addrEq = (bus.cmpWordAddr[i] == bus.reqWordAddr);
            wire armed  = bus.globalEn & bus.cmpEn[i];
            wire common = armed & bus.reqValid & bus.reqInFlash & addrEq;
            if (i < NUM_INST) begin : g_inst
                // Fetch slots see only instruction fetches
                assign bus.hit[i] = common & bus.reqIsFetch;
            end else begin : g_lit
                // Literal slots need a flash load that is naturally aligned
                wire litOk = ~bus.reqIsFetch & bus.reqAligned;
                assign bus.hit[i] = common & litOk;
            end
        end
    endgenerate

endmodule : fpt_match_bank

// ===== rtl/fpt_flash_patch_unit.sv
// Flash patch unit: remaps flash fetches and literal loads to RAM,
// or answers instruction fetches with a breakpoint instruction.
// Assumes one access request per cycle from the core's fetch/load paths,
// answered one cycle later; the core forwards the original flash access
// to the bus itself and uses rspRemap to pick which result it keeps.
//
// Operation
// - Two literal comparators redirect matching flash loads to RAM.
// - Six instruction comparators redirect matching flash fetches to RAM.
// - Each instruction comparator may return a breakpoint instead.
// - One global enable plus one enable per comparator, nine in all.
// - Remap address is 32-byte aligned remap base plus matching comparator offset plus byte lane.
// - Original access still runs; remapped result replaces it.
// - Protection lookups always use the original flash address.
// - Unaligned literal loads never remap; original access goes out.
// - Literal comparators match only loads that target flash.
`timescale 1ns/1ns
`include "fpt_consts.svh"
module fpt_flash_patch_unit #(
    parameter int              NUM_INST    = `FPT_NUM_INST,
    parameter int              NUM_LIT     = `FPT_NUM_LIT,
    parameter logic [31:0]     FLASH_BASE  = `FPT_FLASH_BASE,
    parameter logic [31:0]     FLASH_LIMIT = `FPT_FLASH_LIMIT,
    parameter logic [15:0]     BREAK_INSTR = `FPT_BREAK_INSTR
) (
    input  wire logic                                   clk,
    input  wire logic                                   sys_rst,
    input  wire logic                                   globalEnable,
    input  wire logic [NUM_INST+NUM_LIT-1:0]            cmpEnable,
    input  wire logic [NUM_INST+NUM_LIT-1:0][`FPT_WORD_AW-1:0] cmpWordAddr,
    input  wire logic [NUM_INST-1:0]                    cmpBreakMode,
    input  wire logic [31:0]                            remapBase,
    input  wire logic                                   reqValid,
    input  wire logic                                   reqIsFetch,
    input  wire logic [31:0]                            reqAddr,
    input  wire logic [1:0]                             reqSize,
    output logic                                        rspValid,
    output logic                                        rspRemap,
    output logic [31:0]                                 rspAddr,
    output logic                                        rspBreak,
    output logic [15:0]                                 rspBreakInstr,
    output logic [31:0]                                 rspProtAddr,
    output logic [`FPT_IDX_W-1:0]                       rspHitIndex,
    output logic                                        rspIsFetch
);

    // Instruction slots first, literal slots after them
    localparam int NUM_CMP = NUM_INST + NUM_LIT;
    localparam int IDX_W   = `FPT_IDX_W;

    // Natural alignment: address low bits below the access size are zero
    function automatic logic isAligned(input logic [31:0] a,
                                       input logic [1:0]  sz);
        logic ok;
        ok = 1'b1;
        unique case (fpt_pkg::fpt_size_t'(sz))
            fpt_pkg::FPT_SZ_BYTE: ok = 1'b1;
            fpt_pkg::FPT_SZ_HALF: ok = (a[0] == 1'b0);
            fpt_pkg::FPT_SZ_WORD: ok = (a[1:0] == 2'h0);
            default:              ok = 1'b0;
        endcase
        return ok;
    endfunction : isAligned

    // Lowest numbered hit wins when several comparators hold the same word
    function automatic logic [IDX_W-1:0] firstHit(
        input logic [NUM_CMP-1:0] h);
        logic [IDX_W-1:0] idx;
        idx = '0;
        for (int k = NUM_CMP - 1; k >= 0; k = k - 1) begin
            if (h[k]) begin
                idx = IDX_W'(k);
            end
        end
        return idx;
    endfunction : firstHit

    fpt_cmp_if #(
        .NUM_CMP (NUM_CMP),
        .WORD_AW (`FPT_WORD_AW)
    ) cmpBus ();

    fpt_match_bank #(
        .NUM_CMP  (NUM_CMP),
        .NUM_INST (NUM_INST)
    ) u_bank (
        .bus (cmpBus.bank)
    );

    wire                      inFlash;
    wire                      aligned;
    wire [NUM_CMP-1:0]        hitVec;
    wire                      anyHit;
    wire [IDX_W-1:0]          hitIdx;
    wire                      hitIsInst;
    wire                      breakSel;
    wire [31:0]               remapAddr;
    wire [31:0]               slotOffset;

    assign inFlash = (reqAddr >= FLASH_BASE) && (reqAddr < FLASH_LIMIT);
    assign aligned = isAligned(reqAddr, reqSize);

    assign cmpBus.globalEn    = globalEnable;
    assign cmpBus.cmpEn       = cmpEnable;
    assign cmpBus.cmpWordAddr = cmpWordAddr;
    assign cmpBus.reqValid    = reqValid;
    assign cmpBus.reqIsFetch  = reqIsFetch;
    assign cmpBus.reqAligned  = aligned;
    assign cmpBus.reqInFlash  = inFlash;
    assign cmpBus.reqWordAddr = reqAddr[31:`FPT_SLOT_SHIFT];

    assign hitVec    = cmpBus.hit;
    assign anyHit    = |hitVec;
    assign hitIdx    = firstHit(hitVec);
    assign hitIsInst = (32'(hitIdx) < 32'(NUM_INST));

    // Breakpoint mode overrides remap for that instruction slot
    assign breakSel = anyHit & hitIsInst
                    & cmpBreakMode[hitIdx[IDX_W-1:0] % NUM_INST];

    // Remap table is aligned, each slot one word; the byte lane is kept
    assign slotOffset = {{(32-IDX_W-`FPT_SLOT_SHIFT){1'b0}}, hitIdx,
                         {`FPT_SLOT_SHIFT{1'b0}}};
    assign remapAddr  = {remapBase[31:`FPT_REMAP_LSB],
                         {`FPT_REMAP_LSB{1'b0}}}
                      + slotOffset
                      + {30'h0, reqAddr[1:0]};

    // The core has already sent the flash access, so a remap only
    // tells it which of the two results to keep
    wire             rspValid_next      = reqValid;
    wire             rspIsFetch_next    = reqIsFetch;
    wire             rspRemap_next      = anyHit & ~breakSel;
    wire             rspBreak_next      = breakSel;
    // Misses and unaligned literals pass the original address through
    wire [31:0]      rspAddr_next       =
        rspRemap_next ? remapAddr : reqAddr;
    wire [31:0]      rspProtAddr_next   = reqAddr;
    wire [IDX_W-1:0] rspHitIndex_next   = anyHit ? hitIdx : '0;
    wire [15:0]      rspBreakInstr_next = rspBreak_next ? BREAK_INSTR
                                                        : 16'h0000;

    // Response registers; each output is one of these and nothing else
    logic             rspValid_reg;
    logic             rspIsFetch_reg;
    logic             rspRemap_reg;
    logic             rspBreak_reg;
    logic [31:0]      rspAddr_reg;
    logic [31:0]      rspProtAddr_reg;
    logic [IDX_W-1:0] rspHitIndex_reg;
    logic [15:0]      rspBreakInstr_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rspValid_reg <= 1'b0;
        end else begin
            rspValid_reg <= rspValid_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rspIsFetch_reg <= 1'b0;
        end else begin
            rspIsFetch_reg <= rspIsFetch_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rspRemap_reg <= 1'b0;
        end else begin
            rspRemap_reg <= rspRemap_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rspBreak_reg <= 1'b0;
        end else begin
            rspBreak_reg <= rspBreak_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rspAddr_reg <= 32'h0000_0000;
        end else begin
            rspAddr_reg <= rspAddr_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rspProtAddr_reg <= 32'h0000_0000;
        end else begin
            rspProtAddr_reg <= rspProtAddr_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rspHitIndex_reg <= '0;
        end else begin
            rspHitIndex_reg <= rspHitIndex_next;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rspBreakInstr_reg <= 16'h0000;
        end else begin
            rspBreakInstr_reg <= rspBreakInstr_next;
        end
    end

    // No logic after the flops, so the core sees no decode glitches
    assign rspValid      = rspValid_reg;
    assign rspIsFetch    = rspIsFetch_reg;
    assign rspRemap      = rspRemap_reg;
    assign rspBreak      = rspBreak_reg;
    assign rspAddr       = rspAddr_reg;
    assign rspProtAddr   = rspProtAddr_reg;
    assign rspHitIndex   = rspHitIndex_reg;
    assign rspBreakInstr = rspBreakInstr_reg;

endmodule : fpt_flash_patch_unit

// ===== tb/fpt_fpu_checker.sv
// Checker for the flash patch unit; sees only the unit's top-level ports.
// Assumes the default flash window below 32'h2000_0000.
`timescale 1ns/1ns
`include "fpt_consts.svh"
module fpt_fpu_checker #(
    parameter logic [15:0] BREAK_INSTR = `FPT_BREAK_INSTR
) (
    input wire logic                     clk,
    input wire logic                     sys_rst,
    input wire logic                     globalEnable,
    input wire logic [`FPT_NUM_CMP-1:0]  cmpEnable,
    input wire logic [`FPT_NUM_CMP-1:0][`FPT_WORD_AW-1:0] cmpWordAddr,
    input wire logic [`FPT_NUM_INST-1:0] cmpBreakMode,
    input wire logic [31:0]              remapBase,
    input wire logic                     reqValid,
    input wire logic                     reqIsFetch,
    input wire logic [31:0]              reqAddr,
    input wire logic [1:0]               reqSize,
    input wire logic                     rspValid,
    input wire logic                     rspRemap,
    input wire logic [31:0]              rspAddr,
    input wire logic                     rspBreak,
    input wire logic [15:0]              rspBreakInstr,
    input wire logic [31:0]              rspProtAddr,
    input wire logic [`FPT_IDX_W-1:0]    rspHitIndex,
    input wire logic                     rspIsFetch
);
    wire misAligned = (reqSize == 2'h1 && reqAddr[0]) || reqSize == 2'h3
                   || (reqSize == 2'h2 && reqAddr[1:0] != 2'h0);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    valid_delay_a: assert property (reqValid |=> rspValid)
        else $error("response missing after request");
    prot_addr_a: assert property (
        reqValid |=> rspProtAddr == $past(reqAddr))
        else $error("protection address not the original");
    global_off_a: assert property (reqValid && !globalEnable |=>
        !rspRemap && !rspBreak && rspAddr == $past(reqAddr))
        else $error("match while globally disabled");
    flash_only_a: assert property (reqValid && !reqIsFetch
        && reqAddr >= 32'h2000_0000 |=> !rspRemap)
        else $error("load outside flash remapped");
    unaligned_a: assert property (
        reqValid && !reqIsFetch && misAligned
        |=> !rspRemap && rspAddr == $past(reqAddr))
        else $error("unaligned load remapped");
    remap_addr_a: assert property (rspRemap |-> rspAddr ==
        {$past(remapBase[31:5]), rspHitIndex, $past(reqAddr[1:0])})
        else $error("remap address wrong");
    break_out_a: assert property (rspBreak |->
        !rspRemap && rspIsFetch
        && rspHitIndex < 3'h6 && rspBreakInstr == BREAK_INSTR)
        else $error("breakpoint answer wrong");
    slot_kind_a: assert property (rspRemap |->
        rspIsFetch == (rspHitIndex < 3'h6))
        else $error("remap from wrong comparator kind");
endmodule : fpt_fpu_checker
bind fpt_flash_patch_unit fpt_fpu_checker #(.BREAK_INSTR(BREAK_INSTR)) u_chk (
    .clk, .sys_rst, .globalEnable, .cmpEnable, .cmpWordAddr, .cmpBreakMode,
    .remapBase, .reqValid, .reqIsFetch, .reqAddr, .reqSize, .rspValid,
    .rspRemap, .rspAddr, .rspBreak, .rspBreakInstr, .rspProtAddr,
    .rspHitIndex, .rspIsFetch);

// ===== tb/fpt_core_model.sv
// Core fetch/load path model: presents one access at a time.
// Assumes calls come shortly after a rising edge of clk.
`timescale 1ns/1ns
module fpt_core_model (
    input  wire logic clk,
    output logic      reqValid,
    output logic      reqIsFetch,
    output logic [31:0] reqAddr,
    output logic [1:0]  reqSize
);
    task issue(input logic f, input logic [31:0] a, input logic [1:0] s);
        reqIsFetch = f;
        reqAddr = a;
        reqSize = s;
        reqValid = 1'b1;
    endtask : issue
    // Address and fetch lines flip so a stale address never looks valid
    task release_req;
        reqValid = 1'b0;
        reqAddr = ~reqAddr;
        reqIsFetch = ~reqIsFetch;
    endtask : release_req
    initial begin
        reqAddr = 32'h0;
        reqIsFetch = 1'b0;
        reqSize = 2'h0;
        release_req();
    end
endmodule : fpt_core_model

// ===== tb/fpt_flash_patch_unit_tb.sv
// Directed bench for the flash patch unit.
// Assumes the core model drives requests; config bits are driven here.
`timescale 1ns/1ns
`include "fpt_consts.svh"
module fpt_flash_patch_unit_tb;
    localparam logic [15:0] BRK = 16'hBE01;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic globalEnable = 1'b1;
    logic [`FPT_NUM_CMP-1:0] cmpEnable = 8'hFF;
    logic [`FPT_NUM_CMP-1:0][`FPT_WORD_AW-1:0] cmpWordAddr;
    logic [`FPT_NUM_INST-1:0] cmpBreakMode = 6'h00;
    logic [31:0] remapBase = 32'h2000_005F;
    logic reqValid, reqIsFetch, rspValid, rspRemap, rspBreak, rspIsFetch;
    logic [31:0] reqAddr, rspAddr, rspProtAddr;
    logic [1:0] reqSize;
    logic [15:0] rspBreakInstr;
    logic [2:0] rspHitIndex;
    int badCount = 0, checked = 0, cycles = 0;
    always #4 clk = ~clk;
    fpt_core_model u_core (.clk(clk), .reqValid(reqValid),
        .reqIsFetch(reqIsFetch), .reqAddr(reqAddr), .reqSize(reqSize));
    fpt_flash_patch_unit #(.BREAK_INSTR(BRK)) u_dut (.clk(clk),
        .sys_rst(sys_rst), .globalEnable(globalEnable), .cmpEnable(cmpEnable),
        .cmpWordAddr(cmpWordAddr), .cmpBreakMode(cmpBreakMode),
        .remapBase(remapBase), .reqValid(reqValid), .reqIsFetch(reqIsFetch),
        .reqAddr(reqAddr), .reqSize(reqSize), .rspValid(rspValid),
        .rspRemap(rspRemap), .rspAddr(rspAddr), .rspBreak(rspBreak),
        .rspBreakInstr(rspBreakInstr), .rspProtAddr(rspProtAddr),
        .rspHitIndex(rspHitIndex), .rspIsFetch(rspIsFetch));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            badCount++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    // One request, answer sampled one cycle later
    task acc(input logic f, input logic [31:0] a, input logic [1:0] s,
        input logic er, input logic eb, input logic [31:0] ea,
        input logic [2:0] ei);
        @(posedge clk);
        #2 u_core.issue(f, a, s);
        @(posedge clk);
        #2 u_core.release_req();
        chk("valid", 32'h1, {31'h0, rspValid});
        chk("remap", {31'h0, er}, {31'h0, rspRemap});
        chk("break", {31'h0, eb}, {31'h0, rspBreak});
        chk("addr", ea, rspAddr);
        chk("prot", a, rspProtAddr);
        chk("fetch", {31'h0, f}, {31'h0, rspIsFetch});
        chk("index", {29'h0, (er | eb) ? ei : 3'h0},
            {29'h0, rspHitIndex});
        chk("instr", {16'h0, eb ? BRK : 16'h0},
            {16'h0, rspBreakInstr});
        $display("access %h done", a);
    endtask : acc
    task end_of_test;
        $display("checks %0d, mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            badCount++;
            end_of_test();
        end
    end
    initial begin
        for (int i = 0; i < 8; i++) cmpWordAddr[i] = 30'h40 + 30'(i * 4);
        repeat (8) @(posedge clk);
        #2 chk("reset addr", 32'h0, rspAddr);
        sys_rst = 1'b0;
        for (int i = 0; i < 6; i++) acc(1, 32'h102 + 32'(i * 16), 2'h1, 1, 0,
            32'h2000_0042 + 32'(i * 4), 3'(i));
        acc(0, 32'h160, 2'h2, 1, 0, 32'h2000_0058, 3'h6);
        acc(0, 32'h172, 2'h1, 1, 0, 32'h2000_005E, 3'h7);
        acc(0, 32'h173, 2'h0, 1, 0, 32'h2000_005F, 3'h7);
        acc(1, 32'h160, 2'h1, 0, 0, 32'h160, 3'h0);
        acc(0, 32'h100, 2'h2, 0, 0, 32'h100, 3'h0);
        acc(0, 32'h161, 2'h2, 0, 0, 32'h161, 3'h0);
        acc(0, 32'h161, 2'h1, 0, 0, 32'h161, 3'h0);
        acc(0, 32'h160, 2'h3, 0, 0, 32'h160, 3'h0);
        // Reset while a remap answer stands must clear it at once
        @(posedge clk);
        #2 u_core.issue(1, 32'h102, 2'h1);
        @(posedge clk);
        #2 chk("remap before reset", 32'h1, {31'h0, rspRemap});
        sys_rst = 1'b1;
        u_core.release_req();
        #1 chk("reset remap", 32'h0, {31'h0, rspRemap});
        chk("reset valid", 32'h0, {31'h0, rspValid});
        @(posedge clk);
        #2 sys_rst = 1'b0;
        $display("reset in mid-run done");
        cmpBreakMode = 6'h08;
        acc(1, 32'h130, 2'h1, 0, 1, 32'h130, 3'h3);
        cmpBreakMode = 6'h00;
        cmpEnable = 8'hEF;
        acc(1, 32'h140, 2'h1, 0, 0, 32'h140, 3'h0);
        cmpEnable = 8'hFF;
        globalEnable = 1'b0;
        acc(0, 32'h170, 2'h2, 0, 0, 32'h170, 3'h0);
        globalEnable = 1'b1;
        cmpWordAddr[7] = 30'h0800_0040;
        acc(0, 32'h2000_0100, 2'h2, 0, 0, 32'h2000_0100, 3'h0);
        end_of_test();
    end
endmodule : fpt_flash_patch_unit_tb
